// *** rtl/acqd_pkg.sv ***
// Shared constants, modes, states and carriers of the acquisition decimator.
package acqd_pkg;

  // --------------------------------------------------------------------------
  // Widths and sizes
  // --------------------------------------------------------------------------
  localparam int SW = 8;             // Converter sample width.
  localparam int PW = 16;            // Record point value width.
  localparam int AW = 10;            // Record memory address width.
  localparam int REC_MAX = 1024;     // Deepest record that the memory holds.
  localparam int ACC_W = 24;         // Width of one record memory word.
  localparam logic [ACC_W-1:0] ACC_SAT = 24'hffffff;
  localparam logic [1:0] HIST_FULL = 2'h3;
  localparam int FRAC_SH = 8;        // Fraction bits of the interpolation phase.

  // --------------------------------------------------------------------------
  // Resolution and time base thresholds
  // --------------------------------------------------------------------------
  localparam logic [3:0] BASE_BITS = 4'h8;
  localparam logic [3:0] MAX_BITS = 4'hf;
  localparam logic [31:0] NO_GAIN_NS_DIV = 32'h00000064;     // 100 ns/div.
  localparam logic [31:0] RT_ONLY_INTERP_NS_DIV = 32'h0000000a; // 10 ns/div.

  // --------------------------------------------------------------------------
  // Peak digitizing rates in GS/s after interleaving
  // --------------------------------------------------------------------------
  localparam logic [2:0] RATE_HI = 3'h4;
  localparam logic [2:0] RATE_MID = 3'h2;
  localparam logic [2:0] RATE_LO = 3'h1;

  // --------------------------------------------------------------------------
  // Modes, states and carriers
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_SAMPLE = 3'h0,
    MODE_PEAK = 3'h1,
    MODE_IAVG = 3'h2,
    MODE_ENV = 3'h3,
    MODE_AVG = 3'h4
  } acqd_mode_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARM = 3'b010,
    ST_ACQ = 3'b100
  } acqd_state_e;

  typedef struct packed {
    acqd_mode_e mode;
    logic [31:0] ns_per_div;
    logic [7:0] pts_per_div;
    logic [15:0] rec_points;
    logic [2:0] chans_on;
    logic wide_variant;
    logic rt_only_variant;
    logic repetitive_sampling;
    logic interp_sinc;
    logic persistence_display_mode;
    logic [15:0] acq_target;
  } acqd_cfg_s;

  typedef struct packed {
    logic valid;
    logic [15:0] index;
    logic [PW-1:0] value;
    logic [3:0] res_bits;
  } acqd_point_s;

  typedef struct packed {
    logic running;
    logic [2:0] rate_gs;
    acqd_mode_e mode;
    logic [15:0] acq_count;
    logic rep_required;
    logic seq_done;
  } acqd_readout_s;

endpackage : acqd_pkg

// *** rtl/acqd_decimator.sv ***
// Acquisition decimator: turns converter samples into waveform record points.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Sample mode keeps first sample per interval.
// - Interval is record time over point count.
// - Reset selects sample mode.
// - Peak mode stores max, then min, alternating.
// - Peak falls back to sample when filling.
// - Averaging mode outputs mean of interval samples.
// - Averaging mode falls back to sample when filling.
// - Resolution is 8 plus half log2 count.
// - Resolution never exceeds 15 bits.
// - No resolution gain at 100 ns/div or faster.
// - Envelope keeps max/min in adjacent intervals.
// - Envelope keeps most extreme value per position.
// - Average mode sample-captures then combines per position.
// - Single-trigger modes finish on one trigger.
// - Interpolate only when real samples fall short.
// - Real-time-only variant interpolates below 10 ns/div.
// - Linear fill lies on joining straight line.
// - Band-limited fill follows fitted smooth curve.
// - Idle digitizers raise the peak rate.
// - Too fast time base forces filling.
// - Persistence display blocks multi-sample modes.
// - Count acquisitions, restart on stop or change.
module acqd_decimator (
  input wire logic core_clk,
  input wire logic resetn,
  input wire acqd_pkg::acqd_cfg_s cfg_i,
  input wire logic cfg_load,
  input wire logic run,
  input wire logic trig_pin,
  input wire logic smp_valid,
  input wire logic [acqd_pkg::SW-1:0] smp_data,
  output var acqd_pkg::acqd_point_s point_o,
  output var acqd_pkg::acqd_readout_s readout_o
);

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------
  function automatic logic [2:0] rate_fn(input logic [2:0] chans, input logic wide);
    if (chans <= 3'h1) begin
      rate_fn = wide ? acqd_pkg::RATE_HI : acqd_pkg::RATE_MID;
    end else if (chans == 3'h2) begin
      rate_fn = acqd_pkg::RATE_MID;
    end else begin
      rate_fn = acqd_pkg::RATE_LO;
    end
  endfunction : rate_fn

  function automatic logic [31:0] safe_div(input logic [31:0] a, input logic [31:0] b);
    safe_div = (b == 32'h0) ? a : a / b;
  endfunction : safe_div

  function automatic logic [4:0] log2_fn(input logic [31:0] v);
    log2_fn = 5'h0;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) begin
        log2_fn = 5'(i);
      end
    end
  endfunction : log2_fn

  function automatic logic [7:0] clamp8(input logic signed [31:0] v);
    if (v < 0) begin
      clamp8 = 8'h00;
    end else if (v > 32'sd255) begin
      clamp8 = 8'hff;
    end else begin
      clamp8 = v[7:0];
    end
  endfunction : clamp8

  // --------------------------------------------------------------------------
  // Trigger pin synchroniser
  // --------------------------------------------------------------------------
  logic trig_m_r, trig_s_r, trig_d_r;
  logic trig_edge;

  // Two flops bring the trigger in; the edge is taken after the second.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      trig_m_r <= 1'b0;
      trig_s_r <= 1'b0;
      trig_d_r <= 1'b0;
    end else begin
      trig_m_r <= trig_pin;
      trig_s_r <= trig_m_r;
      trig_d_r <= trig_s_r;
    end
  end
  assign trig_edge = trig_s_r && !trig_d_r;

  // --------------------------------------------------------------------------
  // Settings derived from the latched configuration
  // --------------------------------------------------------------------------
  acqd_pkg::acqd_cfg_s cfg_r, cfg_nxt;
  acqd_pkg::acqd_mode_e mode_sel_r, mode_sel_nxt, eff;
  logic [2:0] rate;
  logic [31:0] spd, nd, nd_eff, r_up;
  logic fill, interp, rep_req;
  logic [3:0] extra;
  logic [4:0] half_lg;

  // Samples per interval follow from the record time over its points.
  assign rate = rate_fn(cfg_r.chans_on, cfg_r.wide_variant);
  assign spd = 32'(cfg_r.ns_per_div * {29'h0, rate});
  assign nd = safe_div(spd, {24'h0, cfg_r.pts_per_div});
  assign fill = (nd == 32'h0)
    || (cfg_r.rt_only_variant && cfg_r.ns_per_div < acqd_pkg::RT_ONLY_INTERP_NS_DIV);
  assign interp = fill && !cfg_r.repetitive_sampling;
  assign rep_req = fill && cfg_r.repetitive_sampling;
  assign nd_eff = fill ? 32'h1 : nd;
  assign half_lg = log2_fn(nd_eff) >> 1;
  assign extra = (cfg_r.ns_per_div <= acqd_pkg::NO_GAIN_NS_DIV) ? 4'h0
    : (half_lg > 5'(acqd_pkg::MAX_BITS - acqd_pkg::BASE_BITS))
    ? (acqd_pkg::MAX_BITS - acqd_pkg::BASE_BITS) : half_lg[3:0];

  // Points per real sample, rounded up, when interpolating.
  always_comb begin
    r_up = safe_div(32'({24'h0, cfg_r.pts_per_div} + spd - 32'h1), spd);
    if (!interp || r_up == 32'h0) begin
      r_up = 32'h1;
    end
  end

  // The processed mode may differ from the selected one, which is kept for readout.
  always_comb begin
    eff = mode_sel_r;
    if (cfg_r.persistence_display_mode && (mode_sel_r == acqd_pkg::MODE_IAVG
        || mode_sel_r == acqd_pkg::MODE_ENV || mode_sel_r == acqd_pkg::MODE_AVG)) begin
      eff = acqd_pkg::MODE_SAMPLE;
    end else if (fill && (mode_sel_r == acqd_pkg::MODE_PEAK
        || mode_sel_r == acqd_pkg::MODE_IAVG)) begin
      eff = acqd_pkg::MODE_SAMPLE;
    end
  end

  // --------------------------------------------------------------------------
  // Record memory for the multi-acquisition modes
  // --------------------------------------------------------------------------
  logic [acqd_pkg::ACC_W-1:0] rec_mem [acqd_pkg::REC_MAX];
  logic mem_we;
  logic [acqd_pkg::AW-1:0] mem_wa;
  logic [acqd_pkg::ACC_W-1:0] mem_wd;

  // The memory holds the running envelope or sum of each position.
  always_ff @(posedge core_clk) begin
    if (mem_we) begin
      rec_mem[mem_wa] <= mem_wd;
    end
  end

  // --------------------------------------------------------------------------
  // Acquisition sequencer and point builder
  // --------------------------------------------------------------------------
  acqd_pkg::acqd_state_e st_r, st_nxt;
  logic [31:0] cnt_r, cnt_nxt, sum_r, sum_nxt, ph_r, ph_nxt;
  logic [7:0] first_r, first_nxt, mx_r, mx_nxt, mn_r, mn_nxt;
  logic [7:0] h0_r, h1_r, h2_r, h3_r, h0_nxt, h1_nxt, h2_nxt, h3_nxt;
  logic [1:0] hcnt_r, hcnt_nxt;
  logic emit_r, emit_nxt;
  logic [15:0] pidx_r, pidx_nxt, ndone_r, ndone_nxt, acq_cnt_r, acq_cnt_nxt;
  acqd_pkg::acqd_point_s pt_r, pt_nxt;
  acqd_pkg::acqd_readout_s rd_r, rd_nxt;

  always_comb begin
    logic emit_now;
    logic [15:0] raw;
    logic [31:0] s, frac;
    logic signed [31:0] a, b, c, y;
    logic [acqd_pkg::ACC_W-1:0] old, w;
    logic [15:0] tgt;
    emit_now = 1'b0;
    raw = 16'h0;
    s = 32'h0;
    frac = 32'h0;
    a = 32'sh0;
    b = 32'sh0;
    c = 32'sh0;
    y = 32'sh0;
    old = rec_mem[pidx_r[acqd_pkg::AW-1:0]];
    w = old;
    tgt = (cfg_r.acq_target == 16'h0) ? 16'h1 : cfg_r.acq_target;
    st_nxt = st_r;
    cfg_nxt = cfg_r;
    mode_sel_nxt = mode_sel_r;
    cnt_nxt = cnt_r;
    sum_nxt = sum_r;
    ph_nxt = ph_r;
    first_nxt = first_r;
    mx_nxt = mx_r;
    mn_nxt = mn_r;
    {h3_nxt, h2_nxt, h1_nxt, h0_nxt} = {h3_r, h2_r, h1_r, h0_r};
    hcnt_nxt = hcnt_r;
    emit_nxt = emit_r;
    pidx_nxt = pidx_r;
    ndone_nxt = ndone_r;
    acq_cnt_nxt = acq_cnt_r;
    pt_nxt = pt_r;
    pt_nxt.valid = 1'b0;
    mem_we = 1'b0;
    mem_wa = pidx_r[acqd_pkg::AW-1:0];
    mem_wd = old;
    rd_nxt.seq_done = 1'b0;
    if (cfg_load) begin
      // A settings change restarts the sequence and the count.
      cfg_nxt = cfg_i;
      mode_sel_nxt = cfg_i.mode;
      acq_cnt_nxt = 16'h0;
      ndone_nxt = 16'h0;
      st_nxt = acqd_pkg::ST_IDLE;
    end else begin
      case (st_r)
        acqd_pkg::ST_IDLE: begin
          if (run) begin
            st_nxt = acqd_pkg::ST_ARM;
            acq_cnt_nxt = 16'h0;
            ndone_nxt = 16'h0;
            pidx_nxt = 16'h0;
            cnt_nxt = 32'h0;
            hcnt_nxt = 2'h0;
            emit_nxt = 1'b0;
          end
        end
        acqd_pkg::ST_ARM: begin
          if (!run) begin
            st_nxt = acqd_pkg::ST_IDLE;
          end else if (trig_edge) begin
            st_nxt = acqd_pkg::ST_ACQ;
            pidx_nxt = 16'h0;
            cnt_nxt = 32'h0;
            hcnt_nxt = 2'h0;
            emit_nxt = 1'b0;
          end
        end
        acqd_pkg::ST_ACQ: begin
          if (!run) begin
            st_nxt = acqd_pkg::ST_IDLE;
          end else if (interp && emit_r) begin
            // One filled point per cycle between the two middle samples.
            frac = safe_div(ph_r << acqd_pkg::FRAC_SH, r_up);
            if (cfg_r.interp_sinc) begin
              a = -$signed({24'h0, h3_r}) + 3 * $signed({24'h0, h2_r})
                - 3 * $signed({24'h0, h1_r}) + $signed({24'h0, h0_r});
              b = 2 * $signed({24'h0, h3_r}) - 5 * $signed({24'h0, h2_r})
                + 4 * $signed({24'h0, h1_r}) - $signed({24'h0, h0_r});
              c = $signed({24'h0, h1_r}) - $signed({24'h0, h3_r});
              y = ((a * $signed(frac)) >>> acqd_pkg::FRAC_SH) + b;
              y = ((y * $signed(frac)) >>> acqd_pkg::FRAC_SH) + c;
              y = ((y * $signed(frac)) >>> acqd_pkg::FRAC_SH) + 2 * $signed({24'h0, h2_r});
              y = y >>> 1;
            end else begin
              y = $signed({24'h0, h2_r}) + (($signed({24'h0, h1_r})
                - $signed({24'h0, h2_r})) * $signed(frac) >>> acqd_pkg::FRAC_SH);
            end
            raw = {8'h0, clamp8(y)};
            emit_now = 1'b1;
            ph_nxt = ph_r + 32'h1;
            emit_nxt = (ph_r + 32'h1 < r_up);
          end else if (interp && smp_valid) begin
            {h3_nxt, h2_nxt, h1_nxt, h0_nxt} = {h2_r, h1_r, h0_r, smp_data};
            hcnt_nxt = (hcnt_r == acqd_pkg::HIST_FULL) ? hcnt_r : hcnt_r + 2'h1;
            emit_nxt = (hcnt_r == acqd_pkg::HIST_FULL);
            ph_nxt = 32'h0;
          end else if (!interp && smp_valid) begin
            // Gather first, extremes and sum of the current interval.
            if (cnt_r == 32'h0) begin
              first_nxt = smp_data;
              mx_nxt = smp_data;
              mn_nxt = smp_data;
              s = {24'h0, smp_data};
            end else begin
              mx_nxt = (smp_data > mx_r) ? smp_data : mx_r;
              mn_nxt = (smp_data < mn_r) ? smp_data : mn_r;
              s = sum_r + {24'h0, smp_data};
            end
            sum_nxt = s;
            cnt_nxt = cnt_r + 32'h1;
            if (cnt_r + 32'h1 >= nd_eff) begin
              cnt_nxt = 32'h0;
              emit_now = 1'b1;
              if (eff == acqd_pkg::MODE_PEAK || eff == acqd_pkg::MODE_ENV) begin
                raw = {8'h0, pidx_r[0] ? mn_nxt : mx_nxt};
              end else if (eff == acqd_pkg::MODE_IAVG) begin
                raw = 16'(safe_div(s << extra, nd_eff));
              end else begin
                raw = {8'h0, first_nxt};
              end
            end
          end
          if (emit_now) begin
            // Combine with earlier acquisitions where the mode asks for it.
            if (eff == acqd_pkg::MODE_ENV) begin
              w = (ndone_r == 16'h0) ? {8'h0, raw} : pidx_r[0]
                ? ((raw < old[15:0]) ? {8'h0, raw} : old)
                : ((raw > old[15:0]) ? {8'h0, raw} : old);
              mem_we = 1'b1;
              raw = w[15:0];
            end else if (eff == acqd_pkg::MODE_AVG) begin
              w = (ndone_r == 16'h0) ? {8'h0, raw} : (old > acqd_pkg::ACC_SAT - {8'h0, raw})
                ? acqd_pkg::ACC_SAT : old + {8'h0, raw};
              mem_we = 1'b1;
              raw = 16'(safe_div({8'h0, w}, {16'h0, ndone_r} + 32'h1));
            end
            mem_wd = w;
            pt_nxt.valid = 1'b1;
            pt_nxt.index = pidx_r;
            pt_nxt.value = raw;
            pt_nxt.res_bits = (eff == acqd_pkg::MODE_IAVG)
              ? acqd_pkg::BASE_BITS + extra : acqd_pkg::BASE_BITS;
            pidx_nxt = pidx_r + 16'h1;
            if (pidx_r + 16'h1 >= cfg_r.rec_points) begin
              // Record complete: count it and rearm for the next trigger.
              st_nxt = acqd_pkg::ST_ARM;
              acq_cnt_nxt = acq_cnt_r + 16'h1;
              if (eff == acqd_pkg::MODE_ENV || eff == acqd_pkg::MODE_AVG) begin
                ndone_nxt = (ndone_r + 16'h1 >= tgt) ? 16'h0 : ndone_r + 16'h1;
                rd_nxt.seq_done = (ndone_r + 16'h1 >= tgt);
              end
            end
          end
        end
        default: st_nxt = acqd_pkg::ST_IDLE;
      endcase
    end
    rd_nxt.running = (st_r != acqd_pkg::ST_IDLE);
    rd_nxt.rate_gs = rate;
    rd_nxt.mode = mode_sel_r;
    rd_nxt.acq_count = acq_cnt_r;
    rd_nxt.rep_required = rep_req;
  end

  // Register the sequencer state; the selected mode resets to sample.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= acqd_pkg::ST_IDLE;
      cfg_r <= '0;
      mode_sel_r <= acqd_pkg::MODE_SAMPLE;
      {cnt_r, sum_r, ph_r} <= '0;
      {first_r, mx_r, mn_r, h0_r, h1_r, h2_r, h3_r} <= '0;
      hcnt_r <= 2'h0;
      emit_r <= 1'b0;
      {pidx_r, ndone_r, acq_cnt_r} <= '0;
      pt_r <= '0;
      rd_r <= '0;
    end else begin
      st_r <= st_nxt;
      cfg_r <= cfg_nxt;
      mode_sel_r <= mode_sel_nxt;
      {cnt_r, sum_r, ph_r} <= {cnt_nxt, sum_nxt, ph_nxt};
      {first_r, mx_r, mn_r} <= {first_nxt, mx_nxt, mn_nxt};
      {h0_r, h1_r, h2_r, h3_r} <= {h0_nxt, h1_nxt, h2_nxt, h3_nxt};
      hcnt_r <= hcnt_nxt;
      emit_r <= emit_nxt;
      {pidx_r, ndone_r, acq_cnt_r} <= {pidx_nxt, ndone_nxt, acq_cnt_nxt};
      pt_r <= pt_nxt;
      rd_r <= rd_nxt;
    end
  end

  assign point_o = pt_r;
  assign readout_o = rd_r;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  logic rst_seen_r;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_seen_r <= 1'b0;
    end else begin
      rst_seen_r <= 1'b1;
    end
  end

  sequence s_armed_trig;
    st_r == acqd_pkg::ST_ARM && run && !cfg_load && trig_edge;
  endsequence

  a_reset_mode: assert property (@(posedge core_clk) disable iff (!resetn)
    !rst_seen_r |-> mode_sel_r == acqd_pkg::MODE_SAMPLE) else $error("mode not sample after reset");
  a_trig_start: assert property (@(posedge core_clk) disable iff (!resetn)
    s_armed_trig |=> st_r == acqd_pkg::ST_ACQ && pidx_r == 16'h0) else $error("trigger not taken");
  a_persist_block: assert property (@(posedge core_clk) disable iff (!resetn)
    cfg_r.persistence_display_mode && mode_sel_r == acqd_pkg::MODE_AVG
    |-> eff == acqd_pkg::MODE_SAMPLE) else $error("multi mode not blocked");
  a_fill_fallback: assert property (@(posedge core_clk) disable iff (!resetn)
    fill && (mode_sel_r == acqd_pkg::MODE_PEAK || mode_sel_r == acqd_pkg::MODE_IAVG)
    |-> eff == acqd_pkg::MODE_SAMPLE) else $error("fallback missing");
  a_res_cap: assert property (@(posedge core_clk) disable iff (!resetn)
    extra <= (acqd_pkg::MAX_BITS - acqd_pkg::BASE_BITS)) else $error("resolution above cap");
  a_no_gain: assert property (@(posedge core_clk) disable iff (!resetn)
    pt_nxt.valid && cfg_r.ns_per_div <= acqd_pkg::NO_GAIN_NS_DIV && !cfg_load
    |=> pt_r.res_bits == acqd_pkg::BASE_BITS) else $error("gain at fast time base");
  a_count_clear: assert property (@(posedge core_clk) disable iff (!resetn)
    cfg_load |=> acq_cnt_r == 16'h0 ##1 rd_r.acq_count == 16'h0) else $error("count not restarted");
  a_sample_first: assert property (@(posedge core_clk) disable iff (!resetn)
    pt_nxt.valid && !interp && eff == acqd_pkg::MODE_SAMPLE
    |=> pt_r.value == {8'h0, first_r}) else $error("first sample lost");
  a_index_range: assert property (@(posedge core_clk) disable iff (!resetn)
    pt_r.valid |-> pt_r.index < cfg_r.rec_points || cfg_r.rec_points == 16'h0)
    else $error("point index beyond record");

endmodule : acqd_decimator

`default_nettype wire

// *** sim/acqd_source.sv ***
// Converter and trigger model that feeds the acquisition decimator.
`timescale 1ns/1ps
`default_nettype none
module acqd_source (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic go,
  input wire logic [7:0] count,
  input wire logic [7:0] ofs,
  output logic trig_pin,
  output logic smp_valid,
  output logic [acqd_pkg::SW-1:0] smp_data
);
  logic [7:0] cyc_r;
  logic [7:0] k_r;

  // A go pulse raises the trigger for four cycles, then sends one sample every other cycle.
  // Between samples the data lines toggle so that a stale value is never mistaken for data.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cyc_r <= 8'hff;
      k_r <= 8'h00;
      trig_pin <= 1'b0;
      smp_valid <= 1'b0;
      smp_data <= 8'h00;
    end else if (go) begin
      cyc_r <= 8'h00;
      k_r <= 8'h00;
    end else begin
      if (cyc_r != 8'hff) cyc_r <= cyc_r + 8'h01;
      trig_pin <= (cyc_r < 8'h04);
      if (cyc_r >= 8'h0a && cyc_r != 8'hff && !cyc_r[0] && k_r < count) begin
        smp_valid <= 1'b1;
        smp_data <= 8'h10 + ((k_r * 8'h25) & 8'h3f) + ofs;
        k_r <= k_r + 8'h01;
      end else begin
        smp_valid <= 1'b0;
        smp_data <= ~smp_data;
      end
    end
  end
endmodule : acqd_source
`default_nettype wire

// *** sim/acqd_decimator_test.sv ***
// Self-checking testbench of the acquisition decimator.
`timescale 1ns/1ps
`default_nettype none
module acqd_decimator_test;
  logic core_clk;
  logic resetn;
  acqd_pkg::acqd_cfg_s cfg_i;
  logic cfg_load;
  logic run;
  logic go;
  logic [7:0] ofs;
  int seq_seen;
  logic trig_pin;
  logic smp_valid;
  logic [7:0] smp_data;
  acqd_pkg::acqd_point_s point_o;
  acqd_pkg::acqd_readout_s readout_o;
  acqd_pkg::acqd_point_s pts[$];
  int num_errors;
  int samples_checked;

  acqd_decimator dut (.core_clk(core_clk), .resetn(resetn), .cfg_i(cfg_i),
    .cfg_load(cfg_load), .run(run), .trig_pin(trig_pin), .smp_valid(smp_valid),
    .smp_data(smp_data), .point_o(point_o), .readout_o(readout_o));

  acqd_source src (.core_clk(core_clk), .resetn(resetn), .go(go), .count(8'h08), .ofs(ofs),
    .trig_pin(trig_pin), .smp_valid(smp_valid), .smp_data(smp_data));

  // Free-running 20 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Collects record points and sequence-end pulses in mid-cycle, where they stand settled.
  always @(negedge core_clk) begin
    if (point_o.valid === 1'b1) pts.push_back(point_o);
    if (readout_o.seq_done === 1'b1) seq_seen++;
  end

  // Value of the k-th sample that the source model sends in the r-th record.
  function automatic logic [7:0] sv(input int k, input int r);
    return 8'h10 + ((8'(k) * 8'h25) & 8'h3f) + 8'(8 * r);
  endfunction : sv

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test();
    $display("Checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test

  // Loads a mode, takes n triggered records of two points and checks the last one.
  // Each point spans spp samples, lags by lag samples and gains g resolution bits.
  task automatic acquire(input acqd_pkg::acqd_mode_e m, input logic pers, input int n,
      input int g, input int spp, input int lag);
    acqd_pkg::acqd_mode_e eff;
    logic [7:0] mx;
    logic [7:0] mn;
    logic [15:0] e;
    int sm;
    int av;
    int w;
    int q;
    @(posedge core_clk);
    cfg_i.mode <= m;
    cfg_i.persistence_display_mode <= pers;
    cfg_i.acq_target <= 16'(n);
    cfg_load <= 1'b1;
    @(posedge core_clk);
    cfg_load <= 1'b0;
    repeat (3) @(posedge core_clk);
    pts.delete();
    seq_seen = 0;
    run <= 1'b1;
    for (int r = 0; r < n; r++) begin
      repeat (3) @(posedge core_clk);
      ofs <= 8'(8 * r);
      go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
      w = 0;
      while (pts.size() < 2 * r + 2 && w < 200) begin
        @(posedge core_clk);
        w++;
      end
    end
    repeat (3) @(posedge core_clk);
    eff = m;
    if (m == acqd_pkg::MODE_AVG) eff = acqd_pkg::MODE_SAMPLE;
    else if (pers && m != acqd_pkg::MODE_PEAK) eff = acqd_pkg::MODE_SAMPLE;
    else if (spp == 1 && m != acqd_pkg::MODE_ENV) eff = acqd_pkg::MODE_SAMPLE;
    else if (m == acqd_pkg::MODE_ENV) eff = acqd_pkg::MODE_PEAK;
    chk(16'(pts.size()), 16'(2 * n));
    for (int p = 0; p < 2 && 2 * n - 2 + p < pts.size(); p++) begin
      q = 2 * n - 2 + p;
      mx = 8'h00;
      mn = 8'hff;
      sm = 0;
      av = 0;
      for (int r = 0; r < n; r++) begin
        av += sv(spp * p + lag, r);
        for (int k = spp * p + lag; k < spp * p + lag + spp; k++) begin
          if (sv(k, r) > mx) mx = sv(k, r);
          if (sv(k, r) < mn) mn = sv(k, r);
          sm += sv(k, r);
        end
      end
      if (eff == acqd_pkg::MODE_PEAK) e = {8'h00, (p == 0) ? mx : mn};
      else if (eff == acqd_pkg::MODE_IAVG) e = 16'((sm << g) / spp);
      else e = 16'(av / n);
      chk(pts[q].index, 16'(p));
      chk(pts[q].value, e);
      chk(16'(pts[q].res_bits), 16'(acqd_pkg::BASE_BITS)
        + ((eff == acqd_pkg::MODE_IAVG) ? 16'(g) : 16'h0000));
    end
    chk(16'(readout_o.mode), 16'(m));
    chk(readout_o.acq_count, 16'(n));
    chk(16'(readout_o.rate_gs), 16'(acqd_pkg::RATE_MID));
    chk(16'(readout_o.rep_required), 16'(cfg_i.repetitive_sampling));
    chk(16'(seq_seen), (!pers && (m == acqd_pkg::MODE_ENV || m == acqd_pkg::MODE_AVG))
      ? 16'h0001 : 16'h0000);
    chk(16'(readout_o.running), 16'h0001);
    run <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk(16'(readout_o.running), 16'h0000);
  endtask : acquire

  // Resets the block, then runs each mode over one record (two for envelope and average), then the gain and fill cases.
  initial begin
    resetn = 1'b0;
    cfg_i = '0;
    cfg_i.ns_per_div = 32'h00000002;
    cfg_i.pts_per_div = 8'h01;
    cfg_i.rec_points = 16'h0002;
    cfg_i.chans_on = 3'h1;
    cfg_i.interp_sinc = 1'b0;
    cfg_i.acq_target = 16'h0001;
    cfg_load = 1'b0;
    run = 1'b0;
    go = 1'b0;
    ofs = 8'h00;
    seq_seen = 0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk(16'(readout_o.mode), 16'(acqd_pkg::MODE_SAMPLE));
    acquire(acqd_pkg::MODE_SAMPLE, 1'b0, 1, 0, 4, 0);
    acquire(acqd_pkg::MODE_PEAK, 1'b0, 1, 0, 4, 0);
    acquire(acqd_pkg::MODE_ENV, 1'b0, 2, 0, 4, 0);
    acquire(acqd_pkg::MODE_AVG, 1'b0, 2, 0, 4, 0);
    acquire(acqd_pkg::MODE_IAVG, 1'b0, 1, 0, 4, 0);
    acquire(acqd_pkg::MODE_IAVG, 1'b1, 1, 0, 4, 0);
    cfg_i.ns_per_div <= 32'h000000c8;
    cfg_i.pts_per_div <= 8'h64;
    acquire(acqd_pkg::MODE_IAVG, 1'b0, 1, 1, 4, 0);
    cfg_i.ns_per_div <= 32'h00000002;
    cfg_i.pts_per_div <= 8'h04;
    cfg_i.rt_only_variant <= 1'b1;
    acquire(acqd_pkg::MODE_PEAK, 1'b0, 1, 0, 1, 1);
    cfg_i.interp_sinc <= 1'b1;
    acquire(acqd_pkg::MODE_PEAK, 1'b0, 1, 0, 1, 1);
    cfg_i.repetitive_sampling <= 1'b1;
    acquire(acqd_pkg::MODE_IAVG, 1'b0, 1, 0, 1, 0);
    stop_test();
  end

  // Cuts a hang short well after all records should be done.
  initial begin
    repeat (5000) @(posedge core_clk);
    num_errors++;
    stop_test();
  end
endmodule : acqd_decimator_test
`default_nettype wire
